/* logic/aux_irq_pkg.sv */
// Register map, field positions and reset values of the auxiliary interrupt block
package aux_irq_pkg;

   // ---------------------------------------------------------------
   // Register addresses on the special-function-register bus
   // ---------------------------------------------------------------
   localparam logic [7:0] PEND_IDX_ADDR    = 8'ha5;
   localparam logic [7:0] AUX_MASK_ADDR    = 8'ha6;
   localparam logic [7:0] AUX_STAT_ADDR    = 8'ha7;
   localparam logic [7:0] LEGACY_MASK_ADDR = 8'ha8;
   localparam logic [7:0] BRK_CTRL_ADDR    = 8'ha9;
   localparam logic [7:0] BRK_LOW_ADDR     = 8'haa;
   localparam logic [7:0] BRK_HIGH_ADDR    = 8'hab;
   localparam logic [7:0] SLOT_SEL_ADDR    = 8'h95;
   localparam logic [7:0] EXT_CTRL_ADDR    = 8'hd8;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] REG_RESET  = 8'h00;
   localparam logic [7:0] READ_ZERO  = 8'h00;
   localparam logic [3:0] PEND_NONE  = 4'h0;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int MASTER_GATE_BIT  = 7;
   localparam int BRK_HIT_BIT      = 7;
   localparam int CODE_SPACE_BIT   = 1;
   localparam int SLOT_EN_BIT      = 0;
   localparam int EXT_AUX_GATE_BIT = 4;
   localparam int LEGACY_SRC_N     = 7;

   // Auxiliary source positions, highest priority at bit 0
   localparam int SRC_DLV_BRK  = 0;
   localparam int SRC_ANALOG   = 1;
   localparam int SRC_SPI_RX   = 2;
   localparam int SRC_SPI_TX   = 3;
   localparam int SRC_MILLISECOND_TICK_FLAG     = 4;
   localparam int SRC_ADC      = 5;
   localparam int SRC_ACCUM    = 6;
   localparam int SRC_ONE_HZ   = 7;
   localparam int AUX_SRC_N    = 8;

   // Legacy source positions, equal to their enable bit
   localparam int LEG_PIN0   = 0;
   localparam int LEG_TMR0   = 1;
   localparam int LEG_PIN1   = 2;
   localparam int LEG_TMR1   = 3;
   localparam int LEG_UART0  = 4;
   localparam int LEG_TMR2   = 5;
   localparam int LEG_UART1  = 6;

endpackage

/* logic/break_slot.sv */
// One hardware address breakpoint slot with its sticky match flag
`timescale 1ns/10ps
module break_slot
   import aux_irq_pkg::*;
#(
   parameter int ADDR_W = 16
)(
   input  wire logic              clk,
   input  wire logic              reset,
   input  wire logic              load,
   input  wire logic              clear,
   input  wire logic              load_enable,
   input  wire logic              load_code,
   input  wire logic [ADDR_W-1:0] load_addr,
   input  wire logic [ADDR_W-1:0] code_addr,
   input  wire logic              code_valid,
   input  wire logic [ADDR_W-1:0] data_addr,
   input  wire logic              data_valid,
   output logic                   enable_q,
   output logic                   code_q,
   output logic                   hit_q
);

   logic [ADDR_W-1:0] addr_q;
   logic              match;

   // ---------------------------------------------------------------
   // Slot condition
   // ---------------------------------------------------------------
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         enable_q <= 1'b0;
         code_q   <= 1'b0;
         addr_q   <= '0;
      end else if (load) begin
         enable_q <= load_enable;
         code_q   <= load_code;
         addr_q   <= load_addr;
      end
   end

   // Program space when set, data space when clear
   always_comb begin
      match = 1'b0;
      if (enable_q) begin
         if (code_q) begin
            match = code_valid && (code_addr == addr_q);
         end else begin
            match = data_valid && (data_addr == addr_q);
         end
      end
   end

   // ---------------------------------------------------------------
   // Sticky match, a new match wins over a clear
   // ---------------------------------------------------------------
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         hit_q <= 1'b0;
      end else if (match) begin
         hit_q <= 1'b1;
      end else if (clear) begin
         hit_q <= 1'b0;
      end
   end

endmodule

/* logic/aux_irq_ctrl.sv */
// Auxiliary and legacy interrupt masking, status, pending index and breakpoints
`timescale 1ns/10ps
module aux_irq_ctrl
   import aux_irq_pkg::*;
#(
   parameter int SLOT_COUNT = 2,
   parameter int ADDR_W     = 16
)(
   input  wire logic              clk,
   input  wire logic              reset,
   input  wire logic [7:0]        sfr_addr,
   input  wire logic [7:0]        sfr_wdata,
   input  wire logic              sfr_wr,
   input  wire logic              sfr_rd,
   output logic [7:0]             sfr_rdata,
   input  wire logic              one_hz_tick_flag,
   input  wire logic              millisecond_tick_flag,
   input  wire logic              spi_tx_level_flag,
   input  wire logic              spi_rx_level_flag,
   input  wire logic              analog_supply_low_flag,
   input  wire logic              digital_supply_low_flag,
   input  wire logic              accum_done,
   input  wire logic              accum_lsb_read,
   input  wire logic              adc_done,
   input  wire logic              adc_lsb_read,
   input  wire logic              uart1_rx_done,
   input  wire logic              uart1_tx_done,
   input  wire logic              timer2_overflow_flag,
   input  wire logic              uart0_rx_done,
   input  wire logic              uart0_tx_done,
   input  wire logic              timer1_overflow_flag,
   input  wire logic              timer0_overflow_flag,
   input  wire logic              pin_irq1_input_n,
   input  wire logic              pin_irq0_input_n,
   input  wire logic [ADDR_W-1:0] code_addr,
   input  wire logic              code_addr_valid,
   input  wire logic [ADDR_W-1:0] data_addr,
   input  wire logic              data_addr_valid,
   output logic                   aux_irq_req,
   output logic [3:0]             aux_pending_index,
   output logic [6:0]             legacy_irq_req,
   output logic                   adc_result_hold,
   output logic                   break_hit_flag
);

   localparam int SEL_W = (SLOT_COUNT > 1) ? $clog2(SLOT_COUNT) : 1;

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   logic [7:0]            aux_mask_q;
   logic [7:0]            legacy_mask_q;
   logic [7:0]            brk_low_q;
   logic [7:0]            brk_high_q;
   logic [7:0]            slot_sel_q;
   logic [7:0]            ext_ctrl_q;
   logic                  accumulator_flag_q;
   logic                  adc_flag_q;
   logic [1:0]            pin_meta_q;
   logic [1:0]            pin_sync_q;
   logic [SLOT_COUNT-1:0] slot_en;
   logic [SLOT_COUNT-1:0] slot_code;
   logic [SLOT_COUNT-1:0] slot_hit;
   logic [SEL_W-1:0]      sel;
   logic                  wr_aux_mask;
   logic                  wr_legacy;
   logic                  wr_brk_ctrl;
   logic                  wr_brk_low;
   logic                  wr_brk_high;
   logic                  wr_slot_sel;
   logic                  wr_ext_ctrl;
   logic                  any_hit;
   logic                  sel_en;
   logic                  sel_code;
   logic [7:0]            aux_raw;
   logic [7:0]            aux_status;
   logic [3:0]            pend_idx;
   logic [6:0]            legacy_src;
   logic [7:0]            brk_ctrl_view;
   logic [7:0]            rdata_d;

   // ---------------------------------------------------------------
   // Write decode
   // ---------------------------------------------------------------
   assign wr_aux_mask = sfr_wr && (sfr_addr == AUX_MASK_ADDR);
   assign wr_legacy   = sfr_wr && (sfr_addr == LEGACY_MASK_ADDR);
   assign wr_brk_ctrl = sfr_wr && (sfr_addr == BRK_CTRL_ADDR);
   assign wr_brk_low  = sfr_wr && (sfr_addr == BRK_LOW_ADDR);
   assign wr_brk_high = sfr_wr && (sfr_addr == BRK_HIGH_ADDR);
   assign wr_slot_sel = sfr_wr && (sfr_addr == SLOT_SEL_ADDR);
   assign wr_ext_ctrl = sfr_wr && (sfr_addr == EXT_CTRL_ADDR);
   assign sel         = slot_sel_q[SEL_W-1:0];

   // ---------------------------------------------------------------
   // Mask and control registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         aux_mask_q <= REG_RESET;
      end else if (wr_aux_mask) begin
         aux_mask_q <= sfr_wdata;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         legacy_mask_q <= REG_RESET;
      end else if (wr_legacy) begin
         legacy_mask_q <= sfr_wdata;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ext_ctrl_q <= REG_RESET;
      end else if (wr_ext_ctrl) begin
         ext_ctrl_q <= sfr_wdata;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         brk_low_q  <= REG_RESET;
         brk_high_q <= REG_RESET;
      end else begin
         if (wr_brk_low) begin
            brk_low_q <= sfr_wdata;
         end
         if (wr_brk_high) begin
            brk_high_q <= sfr_wdata;
         end
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         slot_sel_q <= REG_RESET;
      end else if (wr_slot_sel) begin
         slot_sel_q <= sfr_wdata;
      end
   end

   // ---------------------------------------------------------------
   // Accumulator and converter flags, an event wins over a clear
   // ---------------------------------------------------------------
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         accumulator_flag_q <= 1'b0;
      end else if (accum_done) begin
         accumulator_flag_q <= 1'b1;
      end else if (accum_lsb_read) begin
         accumulator_flag_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         adc_flag_q <= 1'b0;
      end else if (adc_done) begin
         adc_flag_q <= 1'b1;
      end else if (adc_lsb_read) begin
         adc_flag_q <= 1'b0;
      end
   end

   // Blocks the converter from loading its data register
   assign adc_result_hold = adc_flag_q;

   // ---------------------------------------------------------------
   // External interrupt pins, two-stage synchroniser
   // ---------------------------------------------------------------
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pin_meta_q <= 2'h3;
         pin_sync_q <= 2'h3;
      end else begin
         pin_meta_q <= {pin_irq1_input_n, pin_irq0_input_n};
         pin_sync_q <= pin_meta_q;
      end
   end

   // ---------------------------------------------------------------
   // Breakpoint slots
   // ---------------------------------------------------------------
   generate
      for (genvar g = 0; g < SLOT_COUNT; g++) begin : g_slot
         logic chosen;
         assign chosen = (sel == SEL_W'(g));
         break_slot #(
            .ADDR_W (ADDR_W)
         ) u_slot (
            .clk         (clk),
            .reset       (reset),
            .load        (wr_brk_ctrl && chosen),
            .clear       (wr_brk_ctrl && chosen && sfr_wdata[BRK_HIT_BIT]),
            .load_enable (sfr_wdata[SLOT_EN_BIT]),
            .load_code   (sfr_wdata[CODE_SPACE_BIT]),
            .load_addr   (ADDR_W'({brk_high_q, brk_low_q})),
            .code_addr   (code_addr),
            .code_valid  (code_addr_valid),
            .data_addr   (data_addr),
            .data_valid  (data_addr_valid),
            .enable_q    (slot_en[g]),
            .code_q      (slot_code[g]),
            .hit_q       (slot_hit[g])
         );
      end
   endgenerate

   assign any_hit  = |slot_hit;
   assign sel_en   = slot_en[sel];
   assign sel_code = slot_code[sel];

   always_comb begin
      brk_ctrl_view                 = READ_ZERO;
      brk_ctrl_view[BRK_HIT_BIT]    = any_hit;
      brk_ctrl_view[CODE_SPACE_BIT] = sel_code;
      brk_ctrl_view[SLOT_EN_BIT]    = sel_en;
   end

   // ---------------------------------------------------------------
   // Auxiliary sources, status and pending index
   // ---------------------------------------------------------------
   always_comb begin
      aux_raw              = READ_ZERO;
      aux_raw[SRC_ONE_HZ]  = one_hz_tick_flag;
      aux_raw[SRC_ACCUM]   = accumulator_flag_q;
      aux_raw[SRC_ADC]     = adc_flag_q;
      aux_raw[SRC_MILLISECOND_TICK_FLAG]    = millisecond_tick_flag;
      aux_raw[SRC_SPI_TX]  = spi_tx_level_flag;
      aux_raw[SRC_SPI_RX]  = spi_rx_level_flag;
      aux_raw[SRC_ANALOG]  = analog_supply_low_flag;
      aux_raw[SRC_DLV_BRK] = digital_supply_low_flag || any_hit;
   end

   assign aux_status = aux_raw & aux_mask_q;

   // Lowest bit wins; code is bit position plus one
   always_comb begin
      pend_idx = PEND_NONE;
      for (int i = AUX_SRC_N - 1; i >= 0; i--) begin
         if (aux_status[i]) begin
            pend_idx = 4'(i + 1);
         end
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         aux_pending_index <= PEND_NONE;
         aux_irq_req       <= 1'b0;
      end else begin
         aux_pending_index <= pend_idx;
         aux_irq_req       <= ext_ctrl_q[EXT_AUX_GATE_BIT] && (|aux_status);
      end
   end

   // ---------------------------------------------------------------
   // Legacy sources
   // ---------------------------------------------------------------
   always_comb begin
      legacy_src            = '0;
      legacy_src[LEG_PIN0]  = !pin_sync_q[0];
      legacy_src[LEG_TMR0]  = timer0_overflow_flag;
      legacy_src[LEG_PIN1]  = !pin_sync_q[1];
      legacy_src[LEG_TMR1]  = timer1_overflow_flag;
      legacy_src[LEG_UART0] = uart0_rx_done || uart0_tx_done;
      legacy_src[LEG_TMR2]  = timer2_overflow_flag;
      legacy_src[LEG_UART1] = uart1_rx_done || uart1_tx_done;
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         legacy_irq_req <= '0;
      end else if (legacy_mask_q[MASTER_GATE_BIT]) begin
         legacy_irq_req <= legacy_src & legacy_mask_q[LEGACY_SRC_N-1:0];
      end else begin
         legacy_irq_req <= '0;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         break_hit_flag <= 1'b0;
      end else begin
         break_hit_flag <= any_hit;
      end
   end

   // ---------------------------------------------------------------
   // Read data, registered on the read strobe
   // ---------------------------------------------------------------
   always_comb begin
      unique case (sfr_addr)
         PEND_IDX_ADDR:    rdata_d = {4'h0, pend_idx};
         AUX_MASK_ADDR:    rdata_d = aux_raw;
         AUX_STAT_ADDR:    rdata_d = aux_status;
         LEGACY_MASK_ADDR: rdata_d = legacy_mask_q;
         BRK_CTRL_ADDR:    rdata_d = brk_ctrl_view;
         BRK_LOW_ADDR:     rdata_d = brk_low_q;
         BRK_HIGH_ADDR:    rdata_d = brk_high_q;
         SLOT_SEL_ADDR:    rdata_d = slot_sel_q;
         EXT_CTRL_ADDR:    rdata_d = ext_ctrl_q;
         default:          rdata_d = READ_ZERO;
      endcase
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sfr_rdata <= READ_ZERO;
      end else if (sfr_rd) begin
         sfr_rdata <= rdata_d;
      end
   end

endmodule

/* verif/aux_irq_ctrl_chk.sv */
// Port-level assertions for the auxiliary interrupt block
`timescale 1ns/10ps
module aux_irq_ctrl_chk
   import aux_irq_pkg::*;
(
   input wire logic       clk,
   input wire logic       reset,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic       sfr_wr,
   input wire logic       sfr_rd,
   input wire logic [7:0] sfr_rdata,
   input wire logic       one_hz_tick_flag,
   input wire logic       millisecond_tick_flag,
   input wire logic       spi_tx_level_flag,
   input wire logic       spi_rx_level_flag,
   input wire logic       analog_supply_low_flag,
   input wire logic       digital_supply_low_flag,
   input wire logic       adc_done,
   input wire logic       adc_lsb_read,
   input wire logic       uart1_rx_done,
   input wire logic       uart1_tx_done,
   input wire logic       timer2_overflow_flag,
   input wire logic       uart0_rx_done,
   input wire logic       uart0_tx_done,
   input wire logic       timer1_overflow_flag,
   input wire logic       timer0_overflow_flag,
   input wire logic       pin_irq1_input_n,
   input wire logic       pin_irq0_input_n,
   input wire logic       code_addr_valid,
   input wire logic       data_addr_valid,
   input wire logic       aux_irq_req,
   input wire logic [3:0] aux_pending_index,
   input wire logic [6:0] legacy_irq_req,
   input wire logic       adc_result_hold,
   input wire logic       break_hit_flag
);
   // ---------------------------------------------------------------
   // Shadow copies of the writable mask registers and the extension control register
   // ---------------------------------------------------------------
   logic [7:0] aux_q, leg_q, ext_q;
   logic [6:0] leg_en, leg_exp;
   logic [6:0] pin_act;
   logic [4:0] stat_lvl;
   logic       mapped;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         aux_q <= REG_RESET;
         leg_q <= REG_RESET;
         ext_q <= REG_RESET;
      end else if (sfr_wr) begin
         if (sfr_addr == AUX_MASK_ADDR) aux_q <= sfr_wdata;
         if (sfr_addr == LEGACY_MASK_ADDR) leg_q <= sfr_wdata;
         if (sfr_addr == EXT_CTRL_ADDR) ext_q <= sfr_wdata;
      end
   end

   assign leg_en   = leg_q[6:0] & {7{leg_q[MASTER_GATE_BIT]}};
   assign leg_exp  = leg_en & {uart1_rx_done | uart1_tx_done, timer2_overflow_flag,
                     uart0_rx_done | uart0_tx_done, timer1_overflow_flag, 1'b0,
                     timer0_overflow_flag, 1'b0};
   assign pin_act  = {4'h0, !pin_irq1_input_n, 1'b0, !pin_irq0_input_n};
   assign stat_lvl = {one_hz_tick_flag, millisecond_tick_flag, spi_tx_level_flag,
                     spi_rx_level_flag, analog_supply_low_flag} & {aux_q[7], aux_q[4:1]};
   assign mapped   = sfr_addr inside {PEND_IDX_ADDR, AUX_MASK_ADDR, AUX_STAT_ADDR,
                     LEGACY_MASK_ADDR, BRK_CTRL_ADDR, BRK_LOW_ADDR, BRK_HIGH_ADDR,
                     SLOT_SEL_ADDR, EXT_CTRL_ADDR};

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   a_legacy_src_gate: assert property (
      (legacy_irq_req & 7'h7a) == $past(leg_exp)) else $error("legacy request wrong");
   a_pin_req_sync: assert property (
      (legacy_irq_req & 7'h05) == ($past(pin_act, 3) & $past(leg_en)))
      else $error("pin request wrong");
   a_aux_gate_off: assert property (
      !ext_q[EXT_AUX_GATE_BIT] |=> !aux_irq_req) else $error("aux request without gate");
   a_pend_top_src: assert property (
      digital_supply_low_flag && aux_q[SRC_DLV_BRK] |=> aux_pending_index == 4'h1)
      else $error("pending index not top source");
   a_req_has_pend: assert property (
      aux_irq_req |-> aux_pending_index != PEND_NONE) else $error("request without index");
   a_legacy_readback: assert property (
      sfr_rd && sfr_addr == LEGACY_MASK_ADDR |=> sfr_rdata == $past(leg_q))
      else $error("legacy readback wrong");
   a_status_read: assert property (
      sfr_rd && sfr_addr == AUX_STAT_ADDR |=> {sfr_rdata[7], sfr_rdata[4:1]} == $past(stat_lvl))
      else $error("status readback wrong");
   a_unmapped_zero: assert property (
      sfr_rd && !mapped |=> sfr_rdata == READ_ZERO) else $error("unmapped read not zero");
   a_rdata_holds: assert property (
      !sfr_rd |=> $stable(sfr_rdata)) else $error("read data moved");
   a_adc_set_hold: assert property (
      adc_done |=> adc_result_hold) else $error("converter hold missing");
   a_adc_clear: assert property (
      adc_lsb_read && !adc_done |=> !adc_result_hold) else $error("converter flag not cleared");
   a_hit_needs_access: assert property (
      $rose(break_hit_flag) |-> $past(code_addr_valid, 2) || $past(data_addr_valid, 2))
      else $error("hit without access");
endmodule

bind aux_irq_ctrl aux_irq_ctrl_chk i_aux_irq_ctrl_chk (
   .clk, .reset, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata, .one_hz_tick_flag,
   .millisecond_tick_flag, .spi_tx_level_flag, .spi_rx_level_flag, .analog_supply_low_flag,
   .digital_supply_low_flag, .adc_done, .adc_lsb_read, .uart1_rx_done, .uart1_tx_done,
   .timer2_overflow_flag, .uart0_rx_done, .uart0_tx_done, .timer1_overflow_flag,
   .timer0_overflow_flag, .pin_irq1_input_n, .pin_irq0_input_n, .code_addr_valid,
   .data_addr_valid, .aux_irq_req, .aux_pending_index, .legacy_irq_req, .adc_result_hold,
   .break_hit_flag
);

/* verif/testbench.sv */
// Self-checking bench for the auxiliary interrupt block
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin error_cnt++; \
   $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module testbench
   import aux_irq_pkg::*;
;
   logic        clk, reset, sfr_wr, sfr_rd, accum_done, accum_lsb_read, adc_done;
   logic        adc_lsb_read, code_addr_valid, data_addr_valid, m_acc, m_adc, m_hit;
   logic        aux_irq_req, adc_result_hold, break_hit_flag;
   logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, m_aux, m_leg, m_ext;
   logic [15:0] code_addr, data_addr;
   logic [5:0]  lvl;
   logic [8:0]  ls;
   logic [3:0]  aux_pending_index;
   logic [6:0]  legacy_irq_req;
   int          error_cnt, samples_checked, seed, k;
   logic [7:0]  regs [10] = '{PEND_IDX_ADDR, AUX_MASK_ADDR, AUX_STAT_ADDR, LEGACY_MASK_ADDR,
                BRK_CTRL_ADDR, BRK_LOW_ADDR, BRK_HIGH_ADDR, SLOT_SEL_ADDR, EXT_CTRL_ADDR, 8'h3c};
   logic [3:0]  ops [8] = '{4'h1, 4'h4, 4'h3, 4'hc, 4'h2, 4'h8, 4'hc, 4'h8};

   aux_irq_ctrl i_aux_irq_ctrl (
      .clk, .reset, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata,
      .one_hz_tick_flag(lvl[5]), .millisecond_tick_flag(lvl[4]), .spi_tx_level_flag(lvl[3]),
      .spi_rx_level_flag(lvl[2]), .analog_supply_low_flag(lvl[1]),
      .digital_supply_low_flag(lvl[0]), .accum_done, .accum_lsb_read, .adc_done,
      .adc_lsb_read, .uart1_rx_done(ls[7]), .uart1_tx_done(ls[8]),
      .timer2_overflow_flag(ls[6]), .uart0_rx_done(ls[4]), .uart0_tx_done(ls[5]),
      .timer1_overflow_flag(ls[3]), .timer0_overflow_flag(ls[1]),
      .pin_irq1_input_n(!ls[2]), .pin_irq0_input_n(!ls[0]), .code_addr, .code_addr_valid,
      .data_addr, .data_addr_valid, .aux_irq_req, .aux_pending_index, .legacy_irq_req,
      .adc_result_hold, .break_hit_flag
   );

   // ---------------------------------------------------------------
   // Reference model
   // ---------------------------------------------------------------
   function automatic logic [7:0] raw_aux();
      return {lvl[5], m_acc, m_adc, lvl[4:1], lvl[0] | m_hit};
   endfunction

   function automatic logic [3:0] exp_pend(input logic [7:0] st);
      for (int b = 0; b < AUX_SRC_N; b++) if (st[b]) return 4'(b + 1);
      return PEND_NONE;
   endfunction

   function automatic logic [6:0] exp_leg();
      logic [6:0] s;
      s = {ls[8] | ls[7], ls[6], ls[5] | ls[4], ls[3:0]};
      return s & m_leg[6:0] & {7{m_leg[MASTER_GATE_BIT]}};
   endfunction

   // ---------------------------------------------------------------
   // Bus and check tasks
   // ---------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(negedge clk);
      sfr_wr = 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] ex);
      @(negedge clk);
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(negedge clk);
      sfr_rd = 1'b0;
      `CHK("sfr_rdata", ex, sfr_rdata)
   endtask

   task automatic settle();
      repeat (4) @(negedge clk);
   endtask

   task automatic chk_out();
      logic [7:0] st;
      st = raw_aux() & m_aux;
      `CHK("aux_irq_req", m_ext[EXT_AUX_GATE_BIT] & (|st), aux_irq_req)
      `CHK("aux_pending_index", exp_pend(st), aux_pending_index)
      `CHK("legacy_irq_req", exp_leg(), legacy_irq_req)
      `CHK("adc_result_hold", m_adc, adc_result_hold)
   endtask

   task automatic pulse(input logic [3:0] p);
      @(negedge clk);
      {adc_lsb_read, adc_done, accum_lsb_read, accum_done} = p;
      @(negedge clk);
      {adc_lsb_read, adc_done, accum_lsb_read, accum_done} = 4'h0;
   endtask

   task automatic brk(input logic [7:0] sel, input logic [15:0] a, input logic [7:0] ctrl,
                      input logic h);
      wr(BRK_LOW_ADDR, a[7:0]);
      wr(BRK_HIGH_ADDR, a[15:8]);
      wr(SLOT_SEL_ADDR, sel);
      wr(BRK_CTRL_ADDR, ctrl);
      settle();
      m_hit = h;
      `CHK("break_hit_flag", h, break_hit_flag)
      chk_out();
   endtask

   task automatic probe(input logic code, input logic [15:0] a, input logic match);
      @(negedge clk);
      code_addr = a;
      data_addr = a;
      code_addr_valid = code;
      data_addr_valid = !code;
      @(negedge clk);
      {code_addr_valid, data_addr_valid} = 2'b00;
      code_addr = ~a;
      data_addr = ~a;
      settle();
      m_hit = m_hit | match;
      `CHK("break_hit_flag", m_hit, break_hit_flag)
      chk_out();
   endtask

   task automatic report_and_stop();
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Clock, watchdog and main sequence
   // ---------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      report_and_stop();
   end

   initial begin
      reset = 1'b1;
      {sfr_wr, sfr_rd, accum_done, accum_lsb_read, adc_done, adc_lsb_read} = '0;
      {code_addr_valid, data_addr_valid, m_acc, m_adc, m_hit} = '0;
      {sfr_addr, sfr_wdata, m_aux, m_leg, m_ext, code_addr, data_addr, lvl, ls} = '0;
      error_cnt = 0;
      samples_checked = 0;
      seed = 32'h6090;
      repeat (12) @(negedge clk);
      reset = 1'b0;
      foreach (regs[j]) rd(regs[j], READ_ZERO);
      for (k = 0; k < 48; k++) begin
         ls = 9'($random(seed));
         m_leg = 8'($random(seed));
         wr(LEGACY_MASK_ADDR, m_leg);
         settle();
         chk_out();
         `CHK("pin requests", exp_leg() & 7'h05, legacy_irq_req & 7'h05)
         rd(LEGACY_MASK_ADDR, m_leg);
      end
      ls = '0;
      for (k = 0; k < 48; k++) begin
         lvl = 6'($random(seed));
         m_aux = 8'($random(seed));
         m_ext = 8'($random(seed));
         wr(AUX_MASK_ADDR, m_aux);
         wr(EXT_CTRL_ADDR, m_ext);
         wr(AUX_STAT_ADDR, 8'hff);
         settle();
         chk_out();
         rd(AUX_MASK_ADDR, raw_aux());
         rd(AUX_STAT_ADDR, raw_aux() & m_aux);
         rd(PEND_IDX_ADDR, {4'h0, exp_pend(raw_aux() & m_aux)});
      end
      lvl = '0;
      m_aux = 8'h61;
      m_ext = 8'h10;
      wr(AUX_MASK_ADDR, m_aux);
      wr(EXT_CTRL_ADDR, m_ext);
      foreach (ops[j]) begin
         pulse(ops[j]);
         if (ops[j][0]) m_acc = 1'b1;
         else if (ops[j][1]) m_acc = 1'b0;
         if (ops[j][2]) m_adc = 1'b1;
         else if (ops[j][3]) m_adc = 1'b0;
         settle();
         chk_out();
         rd(AUX_STAT_ADDR, raw_aux() & m_aux);
      end
      brk(8'h00, 16'h1234, 8'h03, 1'b0);
      rd(BRK_CTRL_ADDR, 8'h03);
      rd(BRK_HIGH_ADDR, 8'h12);
      probe(1'b0, 16'h1234, 1'b0);
      probe(1'b1, 16'h1334, 1'b0);
      probe(1'b1, 16'h1235, 1'b0);
      probe(1'b1, 16'h1234, 1'b1);
      brk(8'h01, 16'hbeef, 8'h80, 1'b1);
      rd(BRK_CTRL_ADDR, 8'h80);
      brk(8'h00, 16'h1234, 8'h03, 1'b1);
      brk(8'h00, 16'h1234, 8'h80, 1'b0);
      probe(1'b1, 16'h1234, 1'b0);
      brk(8'h01, 16'hbeef, 8'h01, 1'b0);
      probe(1'b1, 16'hbeef, 1'b0);
      probe(1'b0, 16'hbeef, 1'b1);
      brk(8'h00, 16'h1234, 8'h80, 1'b1);
      brk(8'h01, 16'hbeef, 8'h80, 1'b0);
      report_and_stop();
   end
endmodule
